// File: src/dsf_defines.svh
`ifndef DSF_DEFINES_SVH
`define DSF_DEFINES_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DSF_CLK_MHZ 20
`define DSF_PROC_TIME_US 1000
`define DSF_PROC_CYCLES (`DSF_PROC_TIME_US * `DSF_CLK_MHZ)
`define DSF_PROC_MS (`DSF_PROC_TIME_US / 1000)
`define DSF_TENTH_TIME_US 100000
`define DSF_TENTH_PROCS (`DSF_TENTH_TIME_US / `DSF_PROC_TIME_US)

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define DSF_ADDR_ADDER0 8'h00
`define DSF_ADDR_ROUTE 8'h18
`define DSF_ADDR_SQ_HIGH 8'h1c
`define DSF_ADDR_SQ_LOW 8'h20
`define DSF_ADDR_SQ_TIME 8'h24
`define DSF_ADDR_DB_GAIN 8'h28
`define DSF_ADDR_DB_WIDTH 8'h2c
`define DSF_ADDR_DB_VIEW 8'h30
`define DSF_ADDR_DT_GAIN 8'h34
`define DSF_ADDR_DT_TIME 8'h38
`define DSF_ADDR_DT_VIEW 8'h3c
`define DSF_ADDR_DT_RES 8'h40
`define DSF_ADDR_STATUS 8'h44

// ----------------------------------------------------------------
// limits and resets (percent in 0.1 %, gain in 0.01, time as noted)
// ----------------------------------------------------------------
`define DSF_PCT_100 16'sd1000
`define DSF_PCT_200 16'sd2000
`define DSF_GAIN_MAX 16'sd1000
`define DSF_GAIN_ONE 16'sd100
`define DSF_DB_WIDTH_RST 16'sd10
`define DSF_SQ_TIME_RST 16'd1
`define DSF_SQ_TIME_MAX 16'd30000
`define DSF_SQ_STEP1_LIM 16'd100
`define DSF_SQ_STEP2_LIM 16'd1000
`define DSF_DT_TIME_RST 16'd100
`define DSF_DT_TIME_MIN 16'd1
`define DSF_DT_TIME_MAX 16'd500
`define DSF_DT_STEP_LIM 16'd100
`define DSF_RES_MAX 3'h6

`endif

// File: src/dsf_pkg.sv
package dsf_pkg;
  typedef enum logic [1:0] {
    DSF_SQ_HIGH = 2'b01,
    DSF_SQ_LOW = 2'b10
  } dsf_sq_state_t;

  typedef logic signed [15:0] dsf_val_t;

  // limit a wide value to +-200 %
  function automatic dsf_val_t dsf_sat200(input logic signed [47:0] v);
    if (v > 48'sd2000) begin
      return 16'sd2000;
    end else if (v < -48'sd2000) begin
      return -16'sd2000;
    end
    return v[15:0];
  endfunction

  // clamp a setting to a symmetric signed range
  function automatic dsf_val_t dsf_clamp(input dsf_val_t v, input dsf_val_t lim);
    if (v > lim) begin
      return lim;
    end else if (v < -lim) begin
      return -lim;
    end
    return v;
  endfunction
endpackage

// File: src/dsf_deriv.sv
`timescale 1ns/1ps
`include "dsf_defines.svh"
module dsf_deriv
  import dsf_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // processing
  input wire logic tick_i,
  input wire dsf_val_t x_i,
  input wire dsf_val_t gain_i,
  input wire logic [15:0] tv_i,
  input wire logic [2:0] res_i,
  // result
  output dsf_val_t y_o
);
  logic signed [47:0] acc_reg, acc_next;
  dsf_val_t xp_reg, xp_next;
  dsf_val_t y_reg, y_next;
  dsf_val_t xm;
  logic signed [47:0] v, tvms;

  // ----------------------------------------------------------------
  // resolution reduction
  // ----------------------------------------------------------------
  // drop low input bits
  always_comb begin
    xm = x_i;
    if (res_i >= 3'h2 && res_i <= `DSF_RES_MAX) begin
      xm = dsf_val_t'(x_i & (16'hffff << res_i));
    end
  end

  // ----------------------------------------------------------------
  // backward-euler first-order derivative
  // ----------------------------------------------------------------
  // y = a*(y + k*dx), a = t/(t+ts)
  always_comb begin
    acc_next = acc_reg;
    xp_next = xp_reg;
    tvms = 48'(tv_i) * 48'sd10;
    v = acc_reg + (48'(xm - xp_reg) * 48'(gain_i)) / 48'sd100;
    if (tick_i) begin
      acc_next = (v * tvms) / (tvms + 48'(`DSF_PROC_MS));
      xp_next = xm;
    end
    y_next = dsf_sat200(acc_next);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_reg <= '0;
      xp_reg <= '0;
      y_reg <= '0;
    end else begin
      acc_reg <= acc_next;
      xp_reg <= xp_next;
      y_reg <= y_next;
    end
  end

  assign y_o = y_reg;

  dt_out_sat_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (y_reg <= 16'sd2000) && (y_reg >= -16'sd2000)) else $error("derivative exceeds 200 pct");
  dt_res_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (res_i == 3'h6) |-> (xm[5:0] == 6'h00)) else $error("resolution bits not dropped");
  dt_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !tick_i |=> $stable(acc_reg)) else $error("derivative moved between ticks");
endmodule

// File: src/dsf_top.sv
`timescale 1ns/1ps
`include "dsf_defines.svh"
module dsf_top
  import dsf_pkg::*;
#(
  parameter int PROC_CYCLES = `DSF_PROC_CYCLES,
  parameter int TENTH_PROCS = `DSF_TENTH_PROCS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // routed signals
  input wire logic [95:0] adder_src_i,
  input wire dsf_val_t deadband_in_i,
  input wire dsf_val_t deriv_in_i,
  // function block outputs
  output logic [95:0] adder_eff_o,
  output dsf_val_t square_o,
  output dsf_val_t deadband_o,
  output dsf_val_t deriv_o1,
  output dsf_val_t deriv_o2
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [95:0] add_const_reg, add_const_next;
  logic [95:0] add_eff_reg, add_eff_next;
  logic [5:0] route_reg, route_next;
  dsf_val_t sq_high_reg, sq_high_next, sq_low_reg, sq_low_next;
  logic [15:0] sq_time_reg, sq_time_next;
  dsf_val_t db_gain_reg, db_gain_next, db_width_reg, db_width_next;
  dsf_val_t dt_gain_reg, dt_gain_next;
  logic [15:0] dt_time_reg, dt_time_next;
  logic [2:0] dt_res_reg, dt_res_next;
  dsf_val_t db_view_reg, dt_view_reg;
  logic ack_reg, ack_next;
  logic [31:0] dat_reg, dat_next;
  logic [31:0] proc_cnt_reg, proc_cnt_next;
  logic [31:0] tenth_cnt_reg, tenth_cnt_next;
  logic tick_reg, tick_next;
  logic [15:0] sq_cnt_reg, sq_cnt_next;
  dsf_sq_state_t sq_state_reg, sq_state_next;
  dsf_val_t sq_out_reg, sq_out_next;
  dsf_val_t db_out_reg, db_out_next;
  dsf_val_t dt_y;
  dsf_val_t wval;
  logic wr;
  logic tenth;
  logic signed [47:0] db_diff;
  dsf_val_t db_mag;

  // ----------------------------------------------------------------
  // bus access and settings
  // ----------------------------------------------------------------
  // one wait state: ack rises the cycle after the request and drops after
  assign wr = cyc_i && stb_i && we_i && !ack_reg;
  assign wval = dsf_val_t'(dat_i[15:0]);

  always_comb begin
    add_const_next = add_const_reg;
    route_next = route_reg;
    sq_high_next = sq_high_reg;
    sq_low_next = sq_low_reg;
    sq_time_next = sq_time_reg;
    db_gain_next = db_gain_reg;
    db_width_next = db_width_reg;
    dt_gain_next = dt_gain_reg;
    dt_time_next = dt_time_reg;
    dt_res_next = dt_res_reg;
    ack_next = cyc_i && stb_i && !ack_reg;
    dat_next = '0;
    if (wr && sel_i[1:0] == 2'h3) begin
      // constants stored only while the input is unrouted
      if (adr_i < `DSF_ADDR_ROUTE && adr_i[1:0] == 2'h0 && !route_reg[adr_i[4:2]]) begin
        add_const_next[adr_i[4:2]*16 +: 16] = dsf_clamp(wval, `DSF_PCT_200);
      end
      unique case (adr_i)
        `DSF_ADDR_ROUTE: route_next = dat_i[5:0];
        // level settings limited to +-100.0 %
        `DSF_ADDR_SQ_HIGH: sq_high_next = dsf_clamp(wval, `DSF_PCT_100);
        `DSF_ADDR_SQ_LOW: sq_low_next = dsf_clamp(wval, `DSF_PCT_100);
        `DSF_ADDR_SQ_TIME: begin
          if (dat_i[15:0] == 16'h0000) begin
            sq_time_next = `DSF_SQ_TIME_RST;
          end else if (dat_i[15:0] > `DSF_SQ_TIME_MAX) begin
            sq_time_next = `DSF_SQ_TIME_MAX;
          end else if (dat_i[15:0] > `DSF_SQ_STEP2_LIM) begin
            sq_time_next = dat_i[15:0] - (dat_i[15:0] % 16'd100);
          end else if (dat_i[15:0] > `DSF_SQ_STEP1_LIM) begin
            sq_time_next = dat_i[15:0] - (dat_i[15:0] % 16'd10);
          end else begin
            sq_time_next = dat_i[15:0];
          end
        end
        `DSF_ADDR_DB_GAIN: db_gain_next = dsf_clamp(wval, `DSF_GAIN_MAX);
        `DSF_ADDR_DB_WIDTH: begin
          db_width_next = wval[15] ? 16'sd0 : dsf_clamp(wval, `DSF_PCT_100);
        end
        `DSF_ADDR_DT_GAIN: dt_gain_next = dsf_clamp(wval, `DSF_GAIN_MAX);
        `DSF_ADDR_DT_TIME: begin
          // range, 0.1 s steps above 1 s
          if (dat_i[15:0] < `DSF_DT_TIME_MIN) begin
            dt_time_next = `DSF_DT_TIME_MIN;
          end else if (dat_i[15:0] > `DSF_DT_TIME_MAX) begin
            dt_time_next = `DSF_DT_TIME_MAX;
          end else if (dat_i[15:0] > `DSF_DT_STEP_LIM) begin
            dt_time_next = dat_i[15:0] - (dat_i[15:0] % 16'd10);
          end else begin
            dt_time_next = dat_i[15:0];
          end
        end
        `DSF_ADDR_DT_RES: begin
          dt_res_next = (dat_i[2:0] > `DSF_RES_MAX) ? `DSF_RES_MAX : dat_i[2:0];
        end
        default: begin
        end
      endcase
    end
    if (cyc_i && stb_i && !we_i && !ack_reg) begin
      if (adr_i < `DSF_ADDR_ROUTE && adr_i[1:0] == 2'h0) begin
        dat_next = 32'(signed'(add_eff_reg[adr_i[4:2]*16 +: 16]));
      end
      unique case (adr_i)
        `DSF_ADDR_ROUTE: dat_next = {26'h0, route_reg};
        `DSF_ADDR_SQ_HIGH: dat_next = 32'(sq_high_reg);
        `DSF_ADDR_SQ_LOW: dat_next = 32'(sq_low_reg);
        `DSF_ADDR_SQ_TIME: dat_next = {16'h0, sq_time_reg};
        `DSF_ADDR_DB_GAIN: dat_next = 32'(db_gain_reg);
        `DSF_ADDR_DB_WIDTH: dat_next = 32'(db_width_reg);
        `DSF_ADDR_DB_VIEW: dat_next = 32'(db_view_reg);
        `DSF_ADDR_DT_GAIN: dat_next = 32'(dt_gain_reg);
        `DSF_ADDR_DT_TIME: dat_next = {16'h0, dt_time_reg};
        `DSF_ADDR_DT_VIEW: dat_next = 32'(dt_view_reg);
        `DSF_ADDR_DT_RES: dat_next = {29'h0, dt_res_reg};
        `DSF_ADDR_STATUS: dat_next = {30'h0, sq_state_reg};
        default: begin
        end
      endcase
    end
  end

  // effective adder input follows the route or the constant
  generate
    for (genvar i = 0; i < 6; i++) begin : g_add
      assign add_eff_next[i*16 +: 16] = route_reg[i] ? adder_src_i[i*16 +: 16]
                                                    : add_const_reg[i*16 +: 16];
    end
  endgenerate

  // ----------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------
  assign tenth = tick_reg && (tenth_cnt_reg == 32'(TENTH_PROCS - 1));

  always_comb begin
    proc_cnt_next = proc_cnt_reg + 32'd1;
    tick_next = 1'b0;
    tenth_cnt_next = tenth_cnt_reg;
    if (proc_cnt_reg == 32'(PROC_CYCLES - 1)) begin
      proc_cnt_next = '0;
      tick_next = 1'b1;
    end
    if (tick_reg) begin
      tenth_cnt_next = tenth ? 32'd0 : tenth_cnt_reg + 32'd1;
    end
  end

  // ----------------------------------------------------------------
  // square-wave generator
  // ----------------------------------------------------------------
  // a new switch time applies from the next tenth; high<=low is not
  // checked, the output simply alternates between the two settings
  always_comb begin
    sq_state_next = sq_state_reg;
    sq_cnt_next = sq_cnt_reg;
    if (tenth) begin
      sq_cnt_next = sq_cnt_reg + 16'd1;
      if (sq_cnt_reg + 16'd1 >= sq_time_reg) begin
        sq_cnt_next = '0;
        unique case (sq_state_reg)
          DSF_SQ_HIGH: sq_state_next = DSF_SQ_LOW;
          DSF_SQ_LOW: sq_state_next = DSF_SQ_HIGH;
        endcase
      end
    end
    // output level from the two settings
    sq_out_next = (sq_state_next == DSF_SQ_HIGH) ? sq_high_reg : sq_low_reg;
  end

  // ----------------------------------------------------------------
  // dead-band element
  // ----------------------------------------------------------------
  always_comb begin
    db_mag = deadband_in_i[15] ? -deadband_in_i : deadband_in_i;
    db_diff = deadband_in_i[15] ? 48'(deadband_in_i) + 48'(db_width_reg)
                                : 48'(deadband_in_i) - 48'(db_width_reg);
    if (db_mag <= db_width_reg) begin
      db_out_next = '0;
    end else begin
      db_out_next = dsf_sat200((db_diff * 48'(db_gain_reg)) / 48'sd100);
    end
  end

  // ----------------------------------------------------------------
  // derivative element
  // ----------------------------------------------------------------
  dsf_deriv u_deriv (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick_reg),
    .x_i(deriv_in_i),
    .gain_i(dt_gain_reg),
    .tv_i(dt_time_reg),
    .res_i(dt_res_reg),
    .y_o(dt_y)
  );

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      add_const_reg <= '0;
      add_eff_reg <= '0;
      route_reg <= '0;
      sq_high_reg <= '0;
      sq_low_reg <= '0;
      sq_time_reg <= `DSF_SQ_TIME_RST;
      db_gain_reg <= `DSF_GAIN_ONE;
      db_width_reg <= `DSF_DB_WIDTH_RST;
      dt_gain_reg <= `DSF_GAIN_ONE;
      dt_time_reg <= `DSF_DT_TIME_RST;
      dt_res_reg <= '0;
      db_view_reg <= '0;
      dt_view_reg <= '0;
      ack_reg <= 1'b0;
      dat_reg <= '0;
      proc_cnt_reg <= '0;
      tenth_cnt_reg <= '0;
      tick_reg <= 1'b0;
      sq_cnt_reg <= '0;
      // start high and count at once
      sq_state_reg <= DSF_SQ_HIGH;
      sq_out_reg <= '0;
      db_out_reg <= '0;
    end else begin
      add_const_reg <= add_const_next;
      add_eff_reg <= add_eff_next;
      route_reg <= route_next;
      sq_high_reg <= sq_high_next;
      sq_low_reg <= sq_low_next;
      sq_time_reg <= sq_time_next;
      db_gain_reg <= db_gain_next;
      db_width_reg <= db_width_next;
      dt_gain_reg <= dt_gain_next;
      dt_time_reg <= dt_time_next;
      dt_res_reg <= dt_res_next;
      db_view_reg <= deadband_in_i;
      dt_view_reg <= deriv_in_i;
      ack_reg <= ack_next;
      dat_reg <= dat_next;
      proc_cnt_reg <= proc_cnt_next;
      tenth_cnt_reg <= tenth_cnt_next;
      tick_reg <= tick_next;
      sq_cnt_reg <= sq_cnt_next;
      sq_state_reg <= sq_state_next;
      sq_out_reg <= sq_out_next;
      db_out_reg <= db_out_next;
    end
  end

  assign dat_o = dat_reg;
  assign ack_o = ack_reg;
  assign adder_eff_o = add_eff_reg;
  assign square_o = sq_out_reg;
  assign deadband_o = db_out_reg;
  assign deriv_o1 = dt_y;
  assign deriv_o2 = dt_y;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  add_route_view_a: assert property (@(posedge clk_i) disable iff (rst_i)
    route_reg[1] |=> (add_eff_reg[31:16] == $past(adder_src_i[31:16])))
    else $error("routed adder input not shown");
  sq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (sq_state_reg == DSF_SQ_LOW) && $stable(sq_state_reg) |-> (sq_out_reg == $past(sq_low_reg)))
    else $error("square low level wrong");
  sq_switch_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !tenth |=> $stable(sq_state_reg)) else $error("square switched off a tenth");
  sq_time_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (sq_time_reg >= 16'd1) && (sq_time_reg <= 16'd30000)) else $error("switch time out of range");
  db_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (db_mag <= db_width_reg) |=> (db_out_reg == 16'sd0)) else $error("dead band not zero");
  db_gain_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (db_gain_reg <= 16'sd1000) && (db_gain_reg >= -16'sd1000)) else $error("dead-band gain range");
  db_sat_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (db_out_reg <= 16'sd2000) && (db_out_reg >= -16'sd2000)) else $error("dead band over 200 pct");
  dt_time_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (dt_time_reg >= 16'd1) && (dt_time_reg <= 16'd500)) else $error("derivative time range");
  dt_view_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 (dt_view_reg == $past(deriv_in_i))) else $error("input view stale");
endmodule

// File: verification/tb.sv
`timescale 1ns/1ps
module tb;
  import dsf_pkg::*;
  // short processing tick and tenth keep the run small
  localparam int PC = 4;
  localparam int TP = 2;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h0;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic [95:0] adder_src_i = 96'h0;
  dsf_val_t deadband_in_i = 16'h0;
  dsf_val_t deriv_in_i = 16'h0;
  logic [95:0] adder_eff_o;
  dsf_val_t square_o, deadband_o, deriv_o1, deriv_o2;
  int n_mismatch = 0;
  int checked = 0;
  logic [31:0] rd;
  int k, w, g, x, s;

  dsf_top #(.PROC_CYCLES(PC), .TENTH_PROCS(TP)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .adder_src_i(adder_src_i), .deadband_in_i(deadband_in_i), .deriv_in_i(deriv_in_i),
    .adder_eff_o(adder_eff_o), .square_o(square_o), .deadband_o(deadband_o),
    .deriv_o1(deriv_o1), .deriv_o2(deriv_o2)
  );

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // reporting and bus tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] gv, input logic [31:0] ev, input string m);
    checked++;
    if (gv !== ev) begin
      $display("BAD %0t %s got %h exp %h", $time, m, gv, ev);
      n_mismatch++;
    end
  endtask

  // the slave answer time is not assumed; the wait ends on ack or after 20 cycles
  task automatic wb(input logic w_en, input logic [7:0] a, input int d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w_en;
    adr_i <= a;
    sel_i <= 4'hf;
    dat_i <= 32'(d);
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    if (n >= 20) begin
      chk(1'b0, 1'b1, "bus ack timeout");
      final_report();
    end
    @(posedge clk_i);
  endtask

  task automatic rchk(input logic [7:0] a, input int e);
    wb(1'b0, a, 0);
    chk(rd, 32'(e), "register read");
  endtask

  task automatic wrc(input logic [7:0] a, input int v, input int e);
    wb(1'b1, a, v);
    rchk(a, e);
  endtask

  task automatic sq_chg(output int n);
    dsf_val_t v;
    v = square_o;
    n = 0;
    while (square_o === v && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 300) begin
      chk(1'b0, 1'b1, "square timeout");
      final_report();
    end
  endtask

  task automatic dt_wait(input int t);
    int n;
    n = 0;
    while (deriv_o1 !== 16'(t) && n < 600) begin
      @(posedge clk_i);
      n++;
    end
    chk(deriv_o1, 32'(t), "derivative output");
    chk(deriv_o2, deriv_o1, "derivative outputs differ");
    if (n >= 600) begin
      final_report();
    end
  endtask

  function automatic int db_exp(int xi, int wi, int gi);
    int y;
    if (xi <= wi && xi >= -wi) begin
      return 0;
    end
    y = (xi > 0) ? (xi - wi) * gi / 100 : (xi + wi) * gi / 100;
    return (y > 2000) ? 2000 : ((y < -2000) ? -2000 : y);
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h4cfa));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(8'h44, 1);
    rchk(8'h24, 1);
    rchk(8'h28, 100);
    rchk(8'h2c, 10);
    rchk(8'h34, 100);
    rchk(8'h38, 100);
    rchk(8'h48, 0);
    $display("test reset values done");
    wrc(8'h1c, 2000, 1000);
    wrc(8'h20, -1500, -1000);
    wrc(8'h24, 0, 1);
    wrc(8'h24, 155, 150);
    wrc(8'h24, 1234, 1200);
    wrc(8'h24, 40000, 30000);
    wrc(8'h2c, 1500, 1000);
    wrc(8'h28, -1200, -1000);
    wrc(8'h34, 1500, 1000);
    wrc(8'h38, 0, 1);
    wrc(8'h38, 600, 500);
    wrc(8'h38, 257, 250);
    $display("test setting limits done");
    wrc(8'h00, 300, 300);
    wrc(8'h14, -2500, -2000);
    x = $urandom_range(4000) - 2000;
    adder_src_i[31:16] <= 16'(x);
    wb(1'b1, 8'h18, 2);
    wb(1'b1, 8'h04, 77);
    rchk(8'h04, x);
    chk(32'(signed'(adder_eff_o[31:16])), 32'(x), "routed adder input");
    chk(adder_eff_o[15:0], 16'h012c, "constant adder input");
    wb(1'b1, 8'h18, 0);
    rchk(8'h04, 0);
    $display("test adder inputs done");
    wb(1'b1, 8'h1c, 500);
    wb(1'b1, 8'h20, -300);
    wb(1'b1, 8'h24, 2);
    sq_chg(k);
    for (int i = 0; i < 3; i++) begin
      sq_chg(k);
      chk(k, 2 * TP * PC, "square interval");
      s = square_o;
      chk(s == 500 || s == -300, 1, "square level");
    end
    wb(1'b0, 8'h44, 0);
    chk(rd, (s == 500) ? 1 : 2, "square state");
    $display("test square wave done");
    for (int t = 0; t < 3; t++) begin
      w = $urandom_range(200);
      g = (t == 0) ? 1000 : $urandom_range(2000) - 1000;
      wb(1'b1, 8'h2c, w);
      wb(1'b1, 8'h28, g);
      for (int i = 0; i < 14; i++) begin
        case (i)
          0: x = w;
          1: x = -w;
          2: x = w + 1;
          3: x = 2000;
          4: x = -2000;
          default: x = $urandom_range(4000) - 2000;
        endcase
        deadband_in_i <= 16'(x);
        repeat (2) @(posedge clk_i);
        chk(deadband_o, 32'(db_exp(x, w, g)), "dead band output");
      end
      rchk(8'h30, x);
    end
    $display("test dead band done");
    wb(1'b1, 8'h40, 6);
    for (int i = 0; i < 15; i++) begin
      deriv_in_i <= 16'($urandom_range((1 << (2 + i % 5)) - 1));
      wb(1'b1, 8'h40, 2 + i % 5);
      repeat (2 * PC) @(posedge clk_i);
      chk(deriv_o1, 32'h0, "coarse input ignored");
    end
    wb(1'b1, 8'h40, 0);
    wb(1'b1, 8'h34, 1000);
    wb(1'b1, 8'h38, 100);
    deriv_in_i <= 16'sd2000;
    dt_wait(2000);
    deriv_in_i <= -16'sd2000;
    dt_wait(-2000);
    rchk(8'h3c, -2000);
    wb(1'b1, 8'h38, 1);
    dt_wait(0);
    wb(1'b1, 8'h34, -100);
    deriv_in_i <= -16'sd1600;
    dt_wait(-363);
    $display("test derivative done");
    final_report();
  end
endmodule
